// [core/stmu_pkg.sv]
// Package for the status transfer and multiply unit: register map, field positions,
// instruction decode helpers and the state record.
// Assumes a 32-bit APB master and instruction words in the processor's native encoding.
package stmu_pkg;
  // ==========================================================================
  // Register map (byte addresses).
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] INSTR_ADDR = 8'h04;
  localparam logic [7:0] OPA_ADDR = 8'h08;
  localparam logic [7:0] OPS_ADDR = 8'h0C;
  localparam logic [7:0] OPN_ADDR = 8'h10;
  localparam logic [7:0] RESULT_ADDR = 8'h14;
  localparam logic [7:0] STATUS_ADDR = 8'h18;
  localparam logic [7:0] CUR_ADDR = 8'h1C;
  localparam logic [7:0] SAVED_ADDR = 8'h20;
  localparam int CTRL_GO = 0;
  localparam int CTRL_COND = 1;
  // ==========================================================================
  // Status word layout; only twelve bits exist, the rest read as zero.
  localparam logic [31:0] PSR_IMPL = 32'hF00000FF;
  localparam logic [31:0] PSR_FLAGS = 32'hF0000000;
  localparam logic [31:0] PSR_RESET = 32'h000000D3;
  localparam int FLAG_N = 31;
  localparam int FLAG_Z = 30;
  localparam logic [4:0] MODE_USER = 5'h10;
  localparam logic [4:0] MODE_FAST = 5'h11;
  localparam logic [4:0] MODE_IRQ = 5'h12;
  localparam logic [4:0] MODE_SVC = 5'h13;
  localparam logic [4:0] MODE_ABT = 5'h17;
  localparam logic [4:0] MODE_UND = 5'h1B;
  localparam int NUM_SAVED = 5;
  localparam int BOOTH_W = 8;
  localparam int MAX_STEPS = 4;
  // ==========================================================================
  // Instruction fields.
  localparam int B_IMM = 25;
  localparam int B_SAVED = 22;
  localparam int B_ACC = 21;
  localparam int B_WRITE = 21;
  localparam int B_SFLAG = 20;
  localparam int B_FULL = 16;

  typedef enum logic [2:0] {ST_IDLE, ST_STAT, ST_ARRAY, ST_ACCUM, ST_FIN} state_t;

  typedef struct packed {
    state_t st;
    logic [31:0] instr;
    logic [31:0] opa;
    logic [31:0] ops;
    logic [31:0] opn;
    logic cond;
    logic [31:0] result;
    logic res_wr;
    logic done;
    logic [31:0] cur;
    logic [NUM_SAVED-1:0][31:0] saved;
    logic [2:0] step;
    logic [2:0] m;
    logic [2:0] cnt;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } core_state_t;

  // Multiply form: bits 27..22 clear and the 1001 marker in bits 7..4.
  function automatic logic is_mul(input logic [31:0] i);
    return (i[27:22] == 6'h00) && (i[7:4] == 4'h9);
  endfunction : is_mul

  // Status transfer: compare-class opcode (10xx) with the set-flags bit clear.
  function automatic logic is_stat(input logic [31:0] i);
    return (i[27:26] == 2'h0) && (i[24:23] == 2'h2) && !i[B_SFLAG];
  endfunction : is_stat

  // Saved-word bank slot of a mode; out of range for user and system mode.
  function automatic logic [2:0] bank_of(input logic [4:0] mode);
    case (mode)
      MODE_FAST: return 3'h0;
      MODE_IRQ: return 3'h1;
      MODE_SVC: return 3'h2;
      MODE_ABT: return 3'h3;
      MODE_UND: return 3'h4;
      default: return 3'h7;
    endcase
  endfunction : bank_of

  // Array cycles: fewest low bytes above which the multiplier bits are all zero or all one.
  function automatic logic [2:0] m_count(input logic [31:0] v);
    logic [31:0] hi;
    logic [2:0] m;
    m = 3'(MAX_STEPS);
    for (int k = MAX_STEPS - 1; k >= 1; k--) begin
      hi = 32'($signed(v) >>> (BOOTH_W * k));
      if (hi == 32'h0 || hi == 32'hFFFFFFFF) begin
        m = 3'(k);
      end
    end
    return m;
  endfunction : m_count

  // Immediate operand: 8-bit value rotated right by twice the rotate field.
  function automatic logic [31:0] imm_value(input logic [31:0] i);
    logic [63:0] both;
    both = {24'h0, i[7:0], 24'h0, i[7:0]} >> (2 * i[11:8]);
    return both[31:0];
  endfunction : imm_value
endpackage : stmu_pkg

// [core/stmu_core.sv]
// Status transfer and 32-bit multiply / multiply-accumulate unit with an APB slave.
// Software loads an instruction word and the register values it names, then starts it;
// the result and the destination register number are read back, status words stay here.
//
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps

// Function
// RULE1: Execute only when the condition-pass bit is set; else change nothing.
// RULE2: Decode status read/write in compare-class opcodes with set-flags bit clear.
// RULE3: Status read copies the whole current or saved word into the result.
// RULE4: Flags-only write puts source bits 31..28 into N, Z, C, V.
// RULE5: In user mode only bits 31..28 of the current word change.
// RULE6: Privileged full write replaces the whole current or saved word.
// RULE7: Saved word accessed is the copy of the mode active now.
// RULE8: Software never alters the instruction-set state bit through a write.
// RULE9: Software never names R15 nor touches a saved word in user mode.
// RULE10: Only twelve status bits exist; reserved bits read zero.
// RULE11: Software changes control bits by read-modify-write, ignoring reserved bits.
// RULE12: Every status transfer completes in one cycle.
// RULE13: Multiplier consumes eight multiplier bits per array cycle.
// RULE14: Plain multiply writes low 32 product bits, ignoring the accumulate operand.
// RULE15: Multiply-accumulate writes low 32 bits of product plus accumulate operand.
// RULE16: One result serves signed and unsigned operands alike.
// RULE17: Software avoids Rd equal to Rm and R15 in multiplies.
// RULE18: Multiply with set-flags sets N, Z; carry unspecified; overflow kept.
// RULE19: Multiply takes 1+m cycles, multiply-accumulate 1+m+1.
// RULE20: m is 1, 2, 3 by uniform top bits, else 4.
// RULE21: Forbidden register combinations are not detected or trapped.
module stmu_core (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o
);
  import stmu_pkg::*;

  core_state_t q;
  core_state_t d;
  logic access;
  logic commit;
  logic go;
  logic user;
  logic [2:0] bank;
  logic bank_ok;
  logic [31:0] src;
  logic [31:0] digit;
  logic [7:0] byte_v;
  logic last;
  logic [31:0] rdata;
  logic mapped;

  // ==========================================================================
  // Bus decode. A write lands on the edge at which pready is seen high.
  always_comb begin
    access = psel_i && penable_i && !q.pready;
    commit = psel_i && penable_i && q.pready && pwrite_i;
    go = commit && (paddr_i == CTRL_ADDR) && pwdata_i[CTRL_GO] && (q.st == ST_IDLE);
    user = (q.cur[4:0] == MODE_USER);
    bank = bank_of(q.cur[4:0]); // RULE7
    bank_ok = (bank < 3'(NUM_SAVED));
    src = q.instr[B_IMM] ? imm_value(q.instr) : q.opa;
    byte_v = q.ops[BOOTH_W * q.step +: BOOTH_W];
    last = (q.step == q.m - 3'h1);
    // The top step takes the whole sign-filled remainder of the multiplier, so a stop after
    // fewer steps is still exact even when bit 7 of that byte differs from the fill. RULE13 RULE16
    digit = last ? 32'($signed(q.ops) >>> (BOOTH_W * q.step)) : {24'h0, byte_v};
  end

  // Read mux; unused addresses answer with an error and zero data.
  always_comb begin
    mapped = 1'b1;
    case (paddr_i)
      CTRL_ADDR: rdata = {30'h0, q.cond, 1'b0};
      INSTR_ADDR: rdata = q.instr;
      OPA_ADDR: rdata = q.opa;
      OPS_ADDR: rdata = q.ops;
      OPN_ADDR: rdata = q.opn;
      RESULT_ADDR: rdata = q.result;
      STATUS_ADDR: rdata = {16'h0, q.instr[15:12], q.instr[19:16], 1'b0, q.cnt, 1'b0,
                            q.res_wr, q.done, (q.st != ST_IDLE)};
      CUR_ADDR: rdata = q.cur;
      SAVED_ADDR: rdata = bank_ok ? q.saved[bank] : 32'h0;
      default: begin
        rdata = 32'h0;
        mapped = 1'b0;
      end
    endcase
  end

  // ==========================================================================
  // Next state of the whole unit.
  always_comb begin
    d = q;
    d.pready = access;
    d.pslverr = access && !mapped;
    d.prdata = access ? rdata : 32'h0;
    // Operand loads are refused while busy so a running operation stays coherent.
    if (commit && q.st == ST_IDLE) begin
      case (paddr_i)
        CTRL_ADDR: d.cond = pwdata_i[CTRL_COND];
        INSTR_ADDR: d.instr = pwdata_i;
        OPA_ADDR: d.opa = pwdata_i;
        OPS_ADDR: d.ops = pwdata_i;
        OPN_ADDR: d.opn = pwdata_i;
        CUR_ADDR: d.cur = pwdata_i & PSR_IMPL; // RULE10
        SAVED_ADDR: begin
          if (bank_ok) begin
            d.saved[bank] = pwdata_i & PSR_IMPL;
          end
        end
        default: d.cond = q.cond;
      endcase
    end
    case (q.st)
      ST_IDLE: begin
        if (go) begin
          d.done = 1'b0;
          d.res_wr = 1'b0;
          d.cnt = 3'h0;
          if (!q.cond) begin
            d.done = 1'b1; // RULE1
          end else if (is_mul(q.instr)) begin
            // Register numbers are never checked; illegal pairings simply run. RULE21
            d.st = ST_ARRAY;
            d.m = m_count(q.ops); // RULE20
            d.step = 3'h0;
            d.result = 32'h0;
          end else if (is_stat(q.instr)) begin
            d.st = ST_STAT; // RULE2
          end else begin
            d.done = 1'b1;
          end
        end
      end
      ST_STAT: begin
        // Single cycle for either direction. RULE12
        d.st = ST_IDLE;
        d.done = 1'b1;
        if (!q.instr[B_WRITE]) begin
          d.res_wr = 1'b1;
          // No saved word exists in user or system mode; zero comes back. RULE3 RULE9
          d.result = q.instr[B_SAVED] ? (bank_ok ? q.saved[bank] : 32'h0) : q.cur;
        end else if (q.instr[B_SAVED]) begin
          if (bank_ok) begin
            d.saved[bank] = q.instr[B_FULL] ? (src & PSR_IMPL) // RULE6
                : ((q.saved[bank] & ~PSR_FLAGS) | (src & PSR_FLAGS)); // RULE4
          end
        end else if (q.instr[B_FULL] && !user) begin
          d.cur = src & PSR_IMPL; // RULE6
        end else begin
          d.cur = (q.cur & ~PSR_FLAGS) | (src & PSR_FLAGS); // RULE4 RULE5
        end
      end
      ST_ARRAY: begin
        d.result = q.result + 32'(q.opa * (digit << (BOOTH_W * q.step))); // RULE13
        d.step = q.step + 3'h1;
        d.cnt = q.cnt + 3'h1;
        if (last) begin
          d.st = q.instr[B_ACC] ? ST_ACCUM : ST_FIN; // RULE19
        end
      end
      ST_ACCUM: begin
        d.result = q.result + q.opn; // RULE15
        d.cnt = q.cnt + 3'h1;
        d.st = ST_FIN;
      end
      ST_FIN: begin
        // Carry keeps its old value, which is as good as any. RULE18
        d.st = ST_IDLE;
        d.done = 1'b1;
        d.res_wr = 1'b1; // RULE14
        if (q.instr[B_SFLAG]) begin
          d.cur[FLAG_N] = q.result[31];
          d.cur[FLAG_Z] = (q.result == 32'h0);
        end
      end
      default: d.st = ST_IDLE;
    endcase
  end

  // ==========================================================================
  // State register.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
      q.cur <= PSR_RESET;
    end else begin
      q <= d;
    end
  end

  assign prdata_o = q.prdata;
  assign pready_o = q.pready;
  assign pslverr_o = q.pslverr;

  // ==========================================================================
  // Checks.
  chk_cond_skip: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
    (go && !q.cond) |=> (q.st == ST_IDLE) && q.done && $stable(q.cur) && $stable(q.saved))
    else $error("failed condition still changed state");

  chk_stat_single: assert property (@(posedge clk_i) disable iff (rst_i) // RULE12
    (go && q.cond && is_stat(q.instr)) |=> (q.st == ST_STAT) ##1 (q.st == ST_IDLE && q.done))
    else $error("status transfer did not finish in one cycle");

  chk_read_copy: assert property (@(posedge clk_i) disable iff (rst_i) // RULE3
    (q.st == ST_STAT && !q.instr[B_WRITE] && !q.instr[B_SAVED]) |=> q.result == $past(q.cur))
    else $error("status read did not copy the current word");

  chk_user_guard: assert property (@(posedge clk_i) disable iff (rst_i) // RULE5
    (q.st == ST_STAT && q.instr[B_WRITE] && user) |=> q.cur[27:0] == $past(q.cur[27:0]))
    else $error("control bits changed in user mode");

  chk_flag_view: assert property (@(posedge clk_i) disable iff (rst_i) // RULE4
    (q.st == ST_STAT && q.instr[B_WRITE] && !q.instr[B_SAVED] && !q.instr[B_FULL])
    |=> q.cur[31:28] == $past(src[31:28]) && q.cur[7:0] == $past(q.cur[7:0]))
    else $error("flags-only write wrong");

  chk_mul_len: assert property (@(posedge clk_i) disable iff (rst_i) // RULE19 RULE20
    (q.st == ST_FIN) |-> q.cnt == q.m + {2'h0, q.instr[B_ACC]} && q.m == m_count(q.ops))
    else $error("multiply cycle count wrong");

  chk_mul_value: assert property (@(posedge clk_i) disable iff (rst_i) // RULE14 RULE15
    (q.st == ST_FIN) |-> q.result == 32'(q.opa * q.ops + (q.instr[B_ACC] ? q.opn : 32'h0)))
    else $error("multiply result wrong");

  chk_mul_flags: assert property (@(posedge clk_i) disable iff (rst_i) // RULE18
    (q.st == ST_FIN && q.instr[B_SFLAG]) |=> q.cur[FLAG_N] == q.result[31]
    && q.cur[FLAG_Z] == (q.result == 32'h0) && q.cur[28] == $past(q.cur[28]))
    else $error("multiply flags wrong");

  chk_bus_answer: assert property (@(posedge clk_i) disable iff (rst_i)
    (psel_i && penable_i && !q.pready) |=> q.pready)
    else $error("bus answer late");

  // Bus handshake: a one-cycle answer, and an error only alongside it.
  chk_bus_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    q.pready |=> !q.pready)
    else $error("ready stood longer than one cycle");

  chk_bus_error: assert property (@(posedge clk_i) disable iff (rst_i)
    q.pslverr |-> q.pready)
    else $error("error flag without ready");

  // Status word guards; the bank is always the slot of the live mode.
  chk_saved_guard: assert property (@(posedge clk_i) disable iff (rst_i) // RULE7
    (q.st == ST_STAT && q.instr[B_WRITE] && q.instr[B_SAVED] && !bank_ok)
    |=> $stable(q.saved) && $stable(q.cur))
    else $error("saved word written with no bank");

  chk_priv_full: assert property (@(posedge clk_i) disable iff (rst_i) // RULE6
    (q.st == ST_STAT && q.instr[B_WRITE] && !q.instr[B_SAVED] && q.instr[B_FULL] && !user)
    |=> q.cur == ($past(src) & PSR_IMPL))
    else $error("privileged full write did not replace the word");

  chk_saved_full: assert property (@(posedge clk_i) disable iff (rst_i) // RULE6 RULE7
    (q.st == ST_STAT && q.instr[B_WRITE] && q.instr[B_SAVED] && q.instr[B_FULL] && bank_ok)
    |=> q.saved[$past(bank)] == ($past(src) & PSR_IMPL))
    else $error("full write of the saved word wrong");

  chk_saved_read: assert property (@(posedge clk_i) disable iff (rst_i) // RULE3 RULE7
    (q.st == ST_STAT && !q.instr[B_WRITE] && q.instr[B_SAVED] && bank_ok)
    |=> q.result == $past(q.saved[bank]))
    else $error("status read did not copy the saved word");

  chk_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i) // RULE10
    (q.cur & ~PSR_IMPL) == 32'h0
    && (!bank_ok || (q.saved[bank] & ~PSR_IMPL) == 32'h0))
    else $error("reserved status bit set");

  chk_stat_noresult: assert property (@(posedge clk_i) disable iff (rst_i) // RULE12
    (q.st == ST_STAT && q.instr[B_WRITE])
    |=> !q.res_wr && $stable(q.result))
    else $error("status write produced a result");

  // Multiply path: entry, stepping, accumulate and flag handling.
  chk_mul_enter: assert property (@(posedge clk_i) disable iff (rst_i) // RULE20
    (go && q.cond && is_mul(q.instr))
    |=> q.st == ST_ARRAY && q.step == 3'h0 && q.m == m_count(q.ops))
    else $error("multiply started wrongly");

  chk_array_step: assert property (@(posedge clk_i) disable iff (rst_i) // RULE13
    (q.st == ST_ARRAY && !last)
    |=> q.st == ST_ARRAY && q.step == $past(q.step) + 3'h1)
    else $error("array step skipped");

  chk_accum_once: assert property (@(posedge clk_i) disable iff (rst_i) // RULE14 RULE15
    (q.st == ST_ACCUM) |-> q.instr[B_ACC]
    ##1 (q.st == ST_FIN))
    else $error("accumulate step misplaced");

  chk_plain_flags: assert property (@(posedge clk_i) disable iff (rst_i) // RULE18
    (q.st == ST_FIN && !q.instr[B_SFLAG])
    |=> $stable(q.cur))
    else $error("flags changed without set-flags");

  chk_mul_time: assert property (@(posedge clk_i) disable iff (rst_i) // RULE19
    (go && q.cond && is_mul(q.instr))
    |-> ##[3:7] q.done)
    else $error("multiply did not finish in time");
endmodule : stmu_core

// [testbench/status_transfer_and_multiply_unit_tb.sv]
// Self-checking bench for the status transfer and multiply unit.
// Assumes the core's APB slave, its register map and status layout from stmu_pkg.
`timescale 1ns/100ps
module status_transfer_and_multiply_unit_tb;
  import stmu_pkg::*;
  // ==========================================================================
  // Signals and the table of ordinary multiply cases.
  typedef struct packed {
    logic [31:0] ins;
    logic [31:0] a;
    logic [31:0] s;
    logic [31:0] n;
    logic [31:0] res;
    logic [2:0] cyc;
  } row_t;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h00000000;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic [31:0] rdat;
  logic rerr;
  logic [31:0] st;
  int fails = 0;
  int comparisons = 0;
  // Multiplier widths chosen so every array count, and a non-zero ignored Rn, appears.
  row_t rows [6] = '{
    '{32'hE0010392, 32'hFFFFFFF6, 32'h00000014, 32'h00000000, 32'hFFFFFF38, 3'h1},
    '{32'hE0010392, 32'h00000003, 32'h00001234, 32'h00000000, 32'h0000369C, 3'h2},
    '{32'hE0214392, 32'h00000002, 32'h00123456, 32'h00000010, 32'h002468BC, 3'h4},
    '{32'hE0214392, 32'h00010000, 32'h12345678, 32'h00000001, 32'h56780001, 3'h5},
    '{32'hE0010392, 32'h00000007, 32'hFFFFFF00, 32'h0000FFFF, 32'hFFFFF900, 3'h1},
    '{32'hE0010392, 32'hFFFFFFFF, 32'hFFFF0000, 32'h00000000, 32'h00010000, 3'h2}
  };

  stmu_core dut_u (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .pwdata_i(pwdata_i),
    .prdata_o(prdata_o),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o)
  );

  // 125 MHz clock.
  always #4 clk_i = ~clk_i;

  // ==========================================================================
  // Tasks: word compare, one APB transfer, one complete instruction.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // The request is held until pready is seen high; the wait is bounded.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    rdat = prdata_o;
    rerr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (n >= 50) begin
      fails++;
      results();
    end
  endtask : apb

  // The condition bit is written before GO, since GO uses the stored one.
  task automatic run(input logic [31:0] ins, a, s, n, input logic c);
    apb(1'b1, INSTR_ADDR, ins);
    apb(1'b1, OPA_ADDR, a);
    apb(1'b1, OPS_ADDR, s);
    apb(1'b1, OPN_ADDR, n);
    apb(1'b1, CTRL_ADDR, {30'h0, c, 1'b0});
    apb(1'b1, CTRL_ADDR, {30'h0, c, 1'b1});
    for (int k = 0; k < 20; k++) begin
      apb(1'b0, STATUS_ADDR, 32'h0);
      st = rdat;
      if (st[1] === 1'b1) break;
    end
    apb(1'b0, RESULT_ADDR, 32'h0);
  endtask : run

  task automatic results();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results

  // ==========================================================================
  // Main sequence: table loop, then reset and the awkward cases.
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rows[i]) begin
      run(rows[i].ins, rows[i].a, rows[i].s, rows[i].n, 1'b1);
      chk(rdat, rows[i].res);
      chk(32'(st[11:8]), 32'(rows[i].ins[19:16]));
      chk(32'(st[6:4]), 32'(rows[i].cyc));
      chk(32'(st[2]), 32'h1);
    end
    // A second reset, applied while the unit is idle after the table, must restore the reset words.
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    apb(1'b0, CUR_ADDR, 32'h0);
    chk(rdat, PSR_RESET);
    apb(1'b0, SAVED_ADDR, 32'h0);
    chk(rdat, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk(32'(rerr), 32'h1);
    // Reserved bits never stick, even on a privileged full write.
    run(32'hE129F000, 32'h0FFFFFD3, 32'h0, 32'h0, 1'b1);
    apb(1'b0, CUR_ADDR, 32'h0);
    chk(rdat, 32'h000000D3);
    // Overflow is preset so that a multiply that touches it is seen; carry is masked.
    apb(1'b1, CUR_ADDR, 32'h100000D3);
    run(32'hE0110392, 32'hFFFFFFF6, 32'h14, 32'h0, 1'b1);
    apb(1'b0, CUR_ADDR, 32'h0);
    chk(rdat & 32'hD00000FF, 32'h900000D3);
    run(32'hE0110392, 32'h0, 32'h5, 32'h0, 1'b1);
    apb(1'b0, CUR_ADDR, 32'h0);
    chk(rdat & 32'hD00000FF, 32'h500000D3);
    // A failed condition leaves result and flags alone.
    run(32'hE0314392, 32'hFFFFFFFF, 32'h1, 32'h0, 1'b0);
    chk(rdat, 32'h0);
    chk(32'(st[2]), 32'h0);
    apb(1'b0, CUR_ADDR, 32'h0);
    chk(rdat & 32'hD00000FF, 32'h500000D3);
    // Flags-only writes, from an immediate and from a register whose bits 27..0 are all ones.
    run(32'hE328F20A, 32'h0, 32'h0, 32'h0, 1'b1);
    apb(1'b0, CUR_ADDR, 32'h0);
    chk(rdat, 32'hA00000D3);
    run(32'hE128F000, 32'h5FFFFFFF, 32'h0, 32'h0, 1'b1);
    run(32'hE10F1000, 32'h0, 32'h0, 32'h0, 1'b1);
    chk(rdat, 32'h500000D3);
    chk(32'(st[15:12]), 32'h1);
    // Saved word of supervisor mode, then the separate bank of fast interrupt mode.
    run(32'hE169F000, 32'h600000D1, 32'h0, 32'h0, 1'b1);
    run(32'hE14F1000, 32'h0, 32'h0, 32'h0, 1'b1);
    chk(rdat, 32'h600000D1);
    run(32'hE129F000, 32'h000000D1, 32'h0, 32'h0, 1'b1);
    apb(1'b0, SAVED_ADDR, 32'h0);
    chk(rdat, 32'h0);
    // In user mode a full write may only reach the flags.
    run(32'hE129F000, 32'h00000010, 32'h0, 32'h0, 1'b1);
    run(32'hE129F000, 32'h500000D3, 32'h0, 32'h0, 1'b1);
    apb(1'b0, CUR_ADDR, 32'h0);
    chk(rdat, 32'h50000010);
    results();
  end

  // Watchdog: the whole sequence needs well under a tenth of this span.
  initial begin
    repeat (40000) @(posedge clk_i);
    fails++;
    results();
  end
endmodule : status_transfer_and_multiply_unit_tb
